// *** hw/sar_bit_reg.v ***
// sar_bit_reg.v: successive-approximation register with trial bit walker
// assumes comparator decision is already synchronised to clk
`timescale 1ns/1ps
`include "sar_ctrl_map.vh"

module sar_bit_reg #(
  parameter WIDTH = `SAR_RES_BITS
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             loadStart,  // pulse: begin a new approximation
  input  wire             decide,     // pulse: settle current trial bit
  input  wire             compHigh,   // synchronised comparator result
  output reg  [WIDTH-1:0] approx,     // working approximation word
  output reg  [WIDTH-1:0] trialBit,   // one-hot pointer of the bit on trial
  output wire             lastBit     // trial bit is the lsb
);

  //////////////////////////////////////////////////////////////////////////
  // one-hot lsb detection
  assign lastBit = trialBit[0];

  //////////////////////////////////////////////////////////////////////////
  // approximation register update
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      approx   <= `SAR_BIT_RST;
      trialBit <= `SAR_BIT_RST;
    end else if (loadStart) begin
      approx   <= {1'b1, {(WIDTH-1){1'b0}}};
      trialBit <= {1'b1, {(WIDTH-1){1'b0}}};
    end else if (decide && (trialBit != {WIDTH{1'b0}})) begin
      approx   <= (compHigh ? approx : (approx & ~trialBit)) | (trialBit >> 1);
      trialBit <= trialBit >> 1;
    end
  end

endmodule

// *** hw/sar_conversion_control.v ***
// sar_conversion_control.v: sequencer for an 8-bit charge-scaling converter
// assumes comparator input is asynchronous; serial interface on the same clock
`timescale 1ns/1ps
`include "sar_ctrl_map.vh"

module sar_conversion_control #(
  parameter WIDTH     = `SAR_RES_BITS,
  parameter CHW       = `SAR_CHAN_BITS,
  parameter ACQ_NS    = `SAR_ACQ_NS,
  parameter PHASE_NS  = `SAR_PHASE_NS,
  parameter GAP_NS    = `SAR_GAP_NS
) (
  input  wire             clk,
  input  wire             rst,
  // serial interface side
  input  wire             startConv,    // pulse: request a conversion
  input  wire             addressed,    // level: device being addressed
  input  wire [CHW-1:0]   chanSel,      // channel to convert
  input  wire             refExternal,  // level: use external reference
  output reg  [WIDTH-1:0] result,       // last fully resolved result
  output reg              convDone,     // pulse: result updated
  output wire             busy,         // conversion under way
  // analog side
  input  wire             compOut,      // raw comparator output
  output reg  [CHW-1:0]   muxSel,       // input mux address
  output reg              sampleEn,     // acquisition switches closed
  output reg              phi1,         // bottom plates grounded
  output reg              phi2,         // trial caps to reference
  output reg  [WIDTH-1:0] capToRef,     // per-capacitor reference connect
  output reg              refSelExt,    // reference source switch
  output reg              coreEn,       // analog core power
  output reg              clkEn         // internal clock enable
);

  //////////////////////////////////////////////////////////////////////////
  // cycle counts from times; all times round up, none below one cycle
  localparam integer ACQ_RAW   = (ACQ_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS;
  localparam integer PH_RAW    = (PHASE_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS;
  localparam integer GAP_RAW   = (GAP_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS;
  localparam integer ACQ_CYC   = (ACQ_RAW < 1) ? 1 : ACQ_RAW;
  localparam integer PH_CYC    = (PH_RAW < 1) ? 1 : PH_RAW;
  localparam integer GAP_CYC   = (GAP_RAW < 1) ? 1 : GAP_RAW;
  localparam         CNTW      = 16;

  // one-hot states
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_WAKE  = 7'h02;
  localparam [6:0] S_ACQ   = 7'h04;
  localparam [6:0] S_PHI1  = 7'h08;
  localparam [6:0] S_GAP1  = 7'h10;
  localparam [6:0] S_PHI2  = 7'h20;
  localparam [6:0] S_GAP2  = 7'h40;

  reg  [6:0]      state;        // sequencer state
  reg  [6:0]      next_state;   // combinational next state
  reg  [CNTW-1:0] count;        // phase timer
  reg  [CNTW-1:0] next_count;   // timer next value
  reg             compMeta;     // comparator first sync stage
  reg             compSync;     // comparator second sync stage
  reg             loadStart;    // pulse into the bit register
  reg             decide;       // pulse into the bit register
  wire [WIDTH-1:0] approx;      // working word
  wire [WIDTH-1:0] trialBit;    // bit on trial
  wire             lastBit;     // lsb on trial

  assign busy = (state != S_IDLE);

  //////////////////////////////////////////////////////////////////////////
  // bit register instance
  sar_bit_reg #(
    .WIDTH (WIDTH)
  ) u_bits (
    .clk       (clk),
    .rst       (rst),
    .loadStart (loadStart),
    .decide    (decide),
    .compHigh  (compSync),
    .approx    (approx),
    .trialBit  (trialBit),
    .lastBit   (lastBit)
  );

  //////////////////////////////////////////////////////////////////////////
  // comparator synchroniser; only the second stage is read
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      compMeta <= 1'b0;
      compSync <= 1'b0;
    end else begin
      compMeta <= compOut;
      compSync <= compMeta;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // next-state logic
  always @* begin
    next_state = state;
    next_count = count;
    loadStart  = 1'b0;
    decide     = 1'b0;
    case (state)
      S_IDLE: begin
        // power up only on demand
        if (startConv) begin
          next_state = S_WAKE;
          next_count = {CNTW{1'b0}};
        end
      end
      S_WAKE: begin
        // one cycle for core and clock to come on before sampling
        next_state = S_ACQ;
        next_count = ACQ_CYC[CNTW-1:0] - 1'b1;
      end
      S_ACQ: begin
        if (count == {CNTW{1'b0}}) begin
          next_state = S_GAP2;
          next_count = GAP_CYC[CNTW-1:0] - 1'b1;
          loadStart  = 1'b1;
        end else begin
          next_count = count - 1'b1;
        end
      end
      S_PHI1: begin
        if (count == {CNTW{1'b0}}) begin
          next_state = S_GAP1;
          next_count = GAP_CYC[CNTW-1:0] - 1'b1;
        end else begin
          next_count = count - 1'b1;
        end
      end
      S_GAP1: begin
        // both phases low: no overlap
        if (count == {CNTW{1'b0}}) begin
          next_state = S_PHI2;
          next_count = PH_CYC[CNTW-1:0] - 1'b1;
        end else begin
          next_count = count - 1'b1;
        end
      end
      S_PHI2: begin
        if (count == {CNTW{1'b0}}) begin
          decide     = 1'b1;
          next_state = lastBit ? S_IDLE : S_GAP2;
          next_count = GAP_CYC[CNTW-1:0] - 1'b1;
        end else begin
          next_count = count - 1'b1;
        end
      end
      S_GAP2: begin
        // separation before the next grounding phase
        if (count == {CNTW{1'b0}}) begin
          next_state = S_PHI1;
          next_count = PH_CYC[CNTW-1:0] - 1'b1;
        end else begin
          next_count = count - 1'b1;
        end
      end
      default: begin
        next_state = S_IDLE;
        next_count = {CNTW{1'b0}};
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // state, timer and registered analog controls
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state     <= S_IDLE;
      count     <= {CNTW{1'b0}};
      sampleEn  <= 1'b0;
      phi1      <= 1'b0;
      phi2      <= 1'b0;
      capToRef  <= `SAR_ZERO8;
      coreEn    <= 1'b0;
      clkEn     <= 1'b0;
      muxSel    <= {CHW{1'b0}};
      refSelExt <= `SAR_REF_INTERNAL;
    end else begin
      state    <= next_state;
      count    <= next_count;
      sampleEn <= (next_state == S_ACQ);
      phi1     <= (next_state == S_PHI1);
      phi2     <= (next_state == S_PHI2);
      capToRef <= (next_state == S_PHI2) ? approx : `SAR_ZERO8;
      coreEn   <= (next_state != S_IDLE) || addressed;
      clkEn    <= (next_state != S_IDLE) || addressed;
      if (state == S_IDLE && startConv) begin
        muxSel    <= chanSel;
        refSelExt <= refExternal;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // result hold and completion pulse
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      result   <= `SAR_RESULT_RST;
      convDone <= 1'b0;
    end else begin
      convDone <= 1'b0;
      if (decide && lastBit) begin
        result   <= compSync ? approx : (approx & ~trialBit);
        convDone <= 1'b1;
      end
    end
  end

endmodule

// *** hw/sar_ctrl_map.vh ***
// sar_ctrl_map.vh: constants for the successive-approximation control block
// assumes inclusion by bare name from hw/ design files
`ifndef SAR_CTRL_MAP_VH
`define SAR_CTRL_MAP_VH

// result width and channel count
`define SAR_RES_BITS      8
`define SAR_CHAN_BITS     3
`define SAR_CHAN_COUNT    8

// clock period and phase lengths in ns; phases converted to cycles in the control module
`define SAR_CLK_NS        5
`define SAR_ACQ_NS        500
`define SAR_PHASE_NS      20
`define SAR_GAP_NS        5

// reset values
`define SAR_RESULT_RST    8'h00
`define SAR_BIT_RST       8'h00
`define SAR_ZERO8         8'h00

// reference select encodings
`define SAR_REF_INTERNAL  1'b0
`define SAR_REF_EXTERNAL  1'b1

`endif

// *** verif/sar_analog_model.sv ***
// sar_analog_model.sv: behavioural capacitor array and comparator
// assumes the trial word on capToRef is meaningful only while phi2 is high
`timescale 1ns/1ps
module sar_analog_model (
  input  wire logic        clk,
  input  wire logic [2:0]  muxSel,
  input  wire logic        sampleEn,
  input  wire logic        phi2,
  input  wire logic [7:0]  capToRef,
  input  wire logic [63:0] levels,
  output logic             compOut
);
  logic [7:0] held = 8'h00;  // charge left on the array
  logic       junk = 1'b0;   // outside phi2 the comparator means nothing
  always @(posedge clk) begin
    if (sampleEn) held <= levels[muxSel*8 +: 8];
    junk <= ~junk;
  end
  // high when input at or above dac
  assign compOut = phi2 ? (held >= capToRef) : junk;
endmodule

// *** verif/sar_conversion_control_props.sv ***
// sar_conversion_control_props.sv: port checker for the converter sequencer
// assumes one clock domain and rst asynchronous, active high
`timescale 1ns/1ps
module sar_conversion_control_props #(
  parameter WIDTH = 8
) (
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             startConv,
  input wire logic             addressed,
  input wire logic [WIDTH-1:0] result,
  input wire logic             convDone,
  input wire logic             busy,
  input wire logic             sampleEn,
  input wire logic             phi1,
  input wire logic             phi2,
  input wire logic [WIDTH-1:0] capToRef,
  input wire logic             coreEn,
  input wire logic             clkEn
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_phase_apart: assert property (!(phi1 && phi2))
    else $error("both phases high");
  a_cap_quiet: assert property (!phi2 |-> capToRef == 8'h00)
    else $error("caps on reference outside phase two");
  a_sample_alone: assert property (sampleEn |-> !phi1 && !phi2)
    else $error("sampling overlaps conversion");
  a_msb_trial: assert property ($fell(sampleEn) |-> ##[1:8] (phi2 && capToRef == 8'h80))
    else $error("first trial is not msb only");
  a_conv_span: assert property (startConv && !busy |-> ##[80:120] convDone)
    else $error("conversion length wrong");
  a_done_single: assert property (convDone |=> !convDone)
    else $error("done longer than one cycle");
  a_result_hold: assert property ($changed(result) |-> convDone)
    else $error("result changed without done");
  a_idle_power: assert property ((!busy && !addressed)[*4] |-> !coreEn && !clkEn)
    else $error("core powered while idle");
  a_addr_power: assert property (addressed |=> coreEn && clkEn)
    else $error("core off while addressed");
  c_done: cover property (convDone);
  c_refused: cover property (startConv && busy);
  c_addr: cover property (addressed && !busy);
endmodule

bind sar_conversion_control sar_conversion_control_props #(.WIDTH(WIDTH)) u_props (
  .clk, .rst, .startConv, .addressed, .result, .convDone, .busy, .sampleEn,
  .phi1, .phi2, .capToRef, .coreEn, .clkEn);

// *** verif/sar_conversion_control_test.sv ***
// sar_conversion_control_test.sv: self-checking bench for the sequencer
// assumes analog model as comparator and a 5 ns clock
`timescale 1ns/1ps
module sar_conversion_control_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        startConv = 1'b0;
  logic        addressed = 1'b0;
  logic [2:0]  chanSel = 3'h0;
  logic        refExternal = 1'b0;
  logic [63:0] levels = 64'h0;
  wire  [7:0]  result, capToRef;
  wire  [2:0]  muxSel;
  wire         convDone, busy, compOut, sampleEn, phi1, phi2, refSelExt, coreEn, clkEn;
  logic        phiPrev = 1'b0;
  int          err_total = 0, total_checks = 0, cycles = 0, phiCount = 0;
  always #2.5 clk = ~clk;
  // acquisition shortened to keep the run brief
  sar_conversion_control #(.ACQ_NS(10)) dut_u (.clk(clk), .rst(rst),
    .startConv(startConv), .addressed(addressed), .chanSel(chanSel),
    .refExternal(refExternal), .result(result), .convDone(convDone), .busy(busy),
    .compOut(compOut), .muxSel(muxSel), .sampleEn(sampleEn), .phi1(phi1), .phi2(phi2),
    .capToRef(capToRef), .refSelExt(refSelExt), .coreEn(coreEn), .clkEn(clkEn));
  sar_analog_model model_u (.clk(clk), .muxSel(muxSel), .sampleEn(sampleEn),
    .phi2(phi2), .capToRef(capToRef), .levels(levels), .compOut(compOut));
  ////////////////////////////////////////////////////////////////////////
  // count trial phases, sampled on the quiet edge
  always @(negedge clk) begin
    if (phi2 && !phiPrev) phiCount++;
    phiPrev = phi2;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // plain successive approximation against an ideal comparator
  function automatic logic [7:0] expect_sar(input logic [7:0] lvl);
    logic [7:0] w;
    w = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      w[b] = 1'b1;
      if (lvl < w) w[b] = 1'b0;
    end
    return w;
  endfunction
  // one conversion, with a start thrown in while busy that must be ignored
  task automatic convert(input logic [2:0] ch, input logic rx, input logic [7:0] lvl);
    int n;
    @(posedge clk);
    levels[ch*8 +: 8] <= lvl;
    chanSel <= ch;
    refExternal <= rx;
    startConv <= 1'b1;
    @(posedge clk);
    startConv <= 1'b0;
    chanSel <= ~ch;
    refExternal <= ~rx;
    n = 0;
    while (sampleEn !== 1'b1 && n < 20) begin @(negedge clk); n++; end
    check({7'h00, sampleEn}, 8'h01, "acquisition");
    check({5'h00, busy, coreEn, clkEn}, 8'h07, "busy and power");
    check({5'h00, muxSel}, {5'h00, ch}, "channel");
    check({7'h00, refSelExt}, {7'h00, rx}, "reference");
    @(posedge clk);
    startConv <= 1'b1;
    phiCount = 0;
    @(posedge clk);
    startConv <= 1'b0;
    n = 0;
    while (convDone !== 1'b1 && n < 200) begin @(negedge clk); n++; end
    check({7'h00, convDone}, 8'h01, "completion seen");
    check(result, expect_sar(lvl), "result");
    check(phiCount[7:0], 8'h08, "bit periods");
    @(negedge clk);
    check({6'h00, busy, convDone}, 8'h00, "done pulse ended");
    check(result, expect_sar(lvl), "held result");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0]  corner [4];
    logic [31:0] rnd;
    corner = '{8'h00, 8'hFF, 8'h80, 8'h7F};
    void'($urandom(32'h966cd376));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (corner[i]) convert(i[2:0], i[0], corner[i]);
    repeat (12) begin
      rnd = $urandom;
      convert(rnd[2:0], rnd[3], rnd[11:4]);
    end
    // mid-run reset abandons the conversion and clears the result
    @(posedge clk);
    startConv <= 1'b1;
    @(posedge clk);
    startConv <= 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    check(result, 8'h00, "result after reset");
    check({6'h00, busy, coreEn}, 8'h00, "idle after reset");
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    convert(3'h5, 1'b1, 8'hA5);
    repeat (6) @(negedge clk);
    check({6'h00, coreEn, clkEn}, 8'h00, "idle power");
    @(posedge clk);
    addressed <= 1'b1;
    repeat (3) @(negedge clk);
    check({6'h00, coreEn, clkEn}, 8'h03, "addressed power");
    finish_test();
  end
endmodule
